// >>> rdb_pkg.sv
`default_nettype none
package rdb_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [7:0] RDB_OFS_REV_BRAKE = 8'h82;
  localparam logic [7:0] RDB_OFS_STARTUP1 = 8'h84;
  // The reverse-drive word sits at an offset that is not a multiple of four,
  // so both printed offsets are word indices and the byte address is four times.
  localparam logic [9:0] RDB_ADDR_REV_BRAKE = {RDB_OFS_REV_BRAKE, 2'b00};
  localparam logic [9:0] RDB_ADDR_STARTUP1 = {RDB_OFS_STARTUP1, 2'b00};
  localparam logic [31:0] RDB_RST_REV_BRAKE = 32'h0000_0000;
  localparam logic [31:0] RDB_RST_STARTUP1 = 32'h0000_0000;

  // ****************************************************************
  // Field positions of the reverse-drive and braking word.
  // ****************************************************************
  localparam int RDB_LIN_LSB = 27;
  localparam int RDB_QUAD_LSB = 23;
  localparam int RDB_CAP_LSB = 20;
  localparam int RDB_KP_LSB = 10;
  localparam int RDB_KI_LSB = 0;
  localparam int RDB_KP_SHIFT = 7;
  localparam int RDB_KI_SHIFT = 9;

  localparam logic [1:0] RDB_RESP_OKAY = 2'b00;
  localparam logic [1:0] RDB_RESP_SLVERR = 2'b10;

  // ****************************************************************
  // Decoded settings handed to the motor control logic.
  // ****************************************************************
  typedef struct packed {
    logic [23:0] lin_accel_centihz;   // Hz/s times 100.
    logic [23:0] quad_accel_centihz;  // Hz/s2 times 100.
    logic [7:0] cap_halfamp;          // Amperes times 2.
    logic [9:0] kp_raw;               // Gain is kp_raw / 2^7.
    logic [9:0] ki_raw;               // Gain is ki_raw / 2^9.
  } rdb_settings_t;

  // Decode of an all-zero word, so the settings agree with the register from reset onward.
  localparam rdb_settings_t RDB_RST_SETTINGS = '{
    lin_accel_centihz: 24'h00_0001,
    quad_accel_centihz: 24'h00_0000,
    cap_halfamp: 8'h01,
    kp_raw: 10'h000,
    ki_raw: 10'h000
  };

endpackage
`default_nettype wire

// >>> rdb_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rdb_regs (
  // Clock, reset and enable.
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write address and data.
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Settings toward the motor control logic.
  output rdb_pkg::rdb_settings_t settings,
  output logic [31:0] startup_config
);
  import rdb_pkg::*;

  // ****************************************************************
  // Decode tables.
  // ****************************************************************
  // Both acceleration tables share one ladder; only code 0h differs.
  function automatic logic [23:0] accel_centi(input logic [3:0] code, input logic quad);
    logic [23:0] v;
    v = 24'h00_0000;
    case (code)
      4'h0: v = quad ? 24'h00_0000 : 24'h00_0001;
      4'h1: v = 24'h00_0005;
      4'h2: v = 24'h00_0064;
      4'h3: v = 24'h00_00fa;
      4'h4: v = 24'h00_01f4;
      4'h5: v = 24'h00_03e8;
      4'h6: v = 24'h00_09c4;
      4'h7: v = 24'h00_1388;
      4'h8: v = 24'h00_1d4c;
      4'h9: v = 24'h00_2710;
      4'ha: v = 24'h00_61a8;
      4'hb: v = 24'h00_c350;
      4'hc: v = 24'h01_24f8;
      4'hd: v = 24'h01_86a0;
      4'he: v = 24'h07_a120;
      4'hf: v = 24'h0f_4240;
      default: v = 24'h00_0000;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] cap_half(input logic [2:0] code);
    logic [7:0] v;
    v = (code == 3'h0) ? 8'h01 : {4'h0, code, 1'b0};
    return v;
  endfunction

  // ****************************************************************
  // Register state.
  // ****************************************************************
  typedef enum logic [1:0] {RDB_W_IDLE, RDB_W_RESP} rdb_wstate_t;
  rdb_wstate_t wst_reg, wst_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [9:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [1:0] bresp_reg, bresp_next;
  logic [31:0] rev_reg, rev_next, st1_reg, st1_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  rdb_settings_t set_reg, set_next;
  logic awrdy_reg, wrdy_reg, arrdy_reg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // Write channel.
  // ****************************************************************
  always_comb begin
    wst_next = wst_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    rev_next = rev_reg;
    st1_next = st1_reg;
    case (wst_reg)
      RDB_W_IDLE: begin
        if (s_axi_awvalid && awrdy_reg) begin
          aw_have_next = 1'b1;
          awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wrdy_reg) begin
          w_have_next = 1'b1;
          wdata_next = s_axi_wdata;
          wstrb_next = s_axi_wstrb;
        end
        if (aw_have_reg && w_have_reg) begin
          bresp_next = RDB_RESP_OKAY;
          if ({awaddr_reg[9:2], 2'b00} == RDB_ADDR_REV_BRAKE) begin
            rev_next = merge(rev_reg, wdata_reg, wstrb_reg);
          end else if ({awaddr_reg[9:2], 2'b00} == RDB_ADDR_STARTUP1) begin
            st1_next = merge(st1_reg, wdata_reg, wstrb_reg);
          end else begin
            bresp_next = RDB_RESP_SLVERR;
          end
          aw_have_next = 1'b0;
          w_have_next = 1'b0;
          wst_next = RDB_W_RESP;
        end
      end
      RDB_W_RESP: begin
        if (s_axi_bready) begin
          wst_next = RDB_W_IDLE;
        end
      end
      default: wst_next = RDB_W_IDLE;
    endcase
  end

  // ****************************************************************
  // Read channel and decoded settings.
  // ****************************************************************
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg) begin
      if (s_axi_rready) begin
        rvalid_next = 1'b0;
      end
    end else if (s_axi_arvalid && arrdy_reg) begin
      rvalid_next = 1'b1;
      rresp_next = RDB_RESP_OKAY;
      if ({s_axi_araddr[9:2], 2'b00} == RDB_ADDR_REV_BRAKE) begin
        rdata_next = rev_reg;
      end else if ({s_axi_araddr[9:2], 2'b00} == RDB_ADDR_STARTUP1) begin
        rdata_next = st1_reg;
      end else begin
        rdata_next = 32'h0000_0000;
        rresp_next = RDB_RESP_SLVERR;
      end
    end
    set_next.lin_accel_centihz = accel_centi(rev_reg[RDB_LIN_LSB +: 4], 1'b0);
    set_next.quad_accel_centihz = accel_centi(rev_reg[RDB_QUAD_LSB +: 4], 1'b1);
    set_next.cap_halfamp = cap_half(rev_reg[RDB_CAP_LSB +: 3]);
    set_next.kp_raw = rev_reg[RDB_KP_LSB +: 10];
    set_next.ki_raw = rev_reg[RDB_KI_LSB +: 10];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_reg <= RDB_W_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 10'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bresp_reg <= RDB_RESP_OKAY;
      rev_reg <= RDB_RST_REV_BRAKE;
      st1_reg <= RDB_RST_STARTUP1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RDB_RESP_OKAY;
      set_reg <= RDB_RST_SETTINGS;
    end else if (clk_en) begin
      wst_reg <= wst_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bresp_reg <= bresp_next;
      rev_reg <= rev_next;
      st1_reg <= st1_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      set_reg <= set_next;
    end
  end

  // Ready flops load from the next-state values, so they track the state with no
  // lag and cost no extra cycle; each reaches the bus ANDed with clk_en.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awrdy_reg <= 1'b0;
      wrdy_reg <= 1'b0;
      arrdy_reg <= 1'b0;
    end else if (clk_en) begin
      awrdy_reg <= (wst_next == RDB_W_IDLE) && !aw_have_next;
      wrdy_reg <= (wst_next == RDB_W_IDLE) && !w_have_next;
      arrdy_reg <= !rvalid_next;
    end
  end

  // Capture uses the registered ready so that a beat is only taken when the
  // handshake is visible on the bus.
  assign s_axi_awready = awrdy_reg && clk_en;
  assign s_axi_wready = wrdy_reg && clk_en;
  assign s_axi_arready = arrdy_reg && clk_en;
  assign s_axi_bvalid = (wst_reg == RDB_W_RESP);
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign settings = set_reg;
  assign startup_config = st1_reg;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  property p_rev_reset;
    @(posedge aclk) $rose(aresetn) |-> (rev_reg == 32'h0000_0000);
  endproperty
  a_rev_reset: assert property (p_rev_reset) else $error("reverse word not zero after reset");
  property p_st1_reset;
    @(posedge aclk) $rose(aresetn) |-> (startup_config == 32'h0000_0000);
  endproperty
  a_st1_reset: assert property (p_st1_reset) else $error("startup word not zero after reset");
  property p_lin;
    @(posedge aclk) disable iff (!aresetn)
      clk_en |=> settings.lin_accel_centihz == accel_centi($past(rev_reg[30:27]), 1'b0);
  endproperty
  a_lin: assert property (p_lin) else $error("linear rate decode wrong");
  property p_quad;
    @(posedge aclk) disable iff (!aresetn)
      clk_en && rev_reg[26:23] == 4'h0 |=> settings.quad_accel_centihz == 24'h00_0000;
  endproperty
  a_quad: assert property (p_quad) else $error("quadratic zero code wrong");
  property p_cap;
    @(posedge aclk) disable iff (!aresetn)
      clk_en && rev_reg[22:20] == 3'h7 |=> settings.cap_halfamp == 8'h0e;
  endproperty
  a_cap: assert property (p_cap) else $error("current cap decode wrong");
  property p_kp;
    @(posedge aclk) disable iff (!aresetn) clk_en |=> settings.kp_raw == $past(rev_reg[19:10]);
  endproperty
  a_kp: assert property (p_kp) else $error("proportional gain field wrong");
  property p_ki;
    @(posedge aclk) disable iff (!aresetn) clk_en |=> settings.ki_raw == $past(rev_reg[9:0]);
  endproperty
  a_ki: assert property (p_ki) else $error("integral gain field wrong");
  sequence s_wr_st1;
    clk_en && wst_reg == RDB_W_IDLE && aw_have_reg && w_have_reg &&
      awaddr_reg[9:2] == RDB_OFS_STARTUP1 && wstrb_reg == 4'hf;
  endsequence
  property p_wr_st1;
    @(posedge aclk) disable iff (!aresetn) s_wr_st1 |=> startup_config == $past(wdata_reg);
  endproperty
  a_wr_st1: assert property (p_wr_st1) else $error("startup word write lost");
  sequence s_wr_rev;
    clk_en && wst_reg == RDB_W_IDLE && aw_have_reg && w_have_reg &&
      awaddr_reg[9:2] == RDB_OFS_REV_BRAKE && wstrb_reg == 4'hf;
  endsequence
  property p_wr_rev;
    @(posedge aclk) disable iff (!aresetn) s_wr_rev |=> rev_reg == $past(wdata_reg);
  endproperty
  a_wr_rev: assert property (p_wr_rev) else $error("reverse word write lost");
  property p_cap_half;
    @(posedge aclk) disable iff (!aresetn)
      clk_en && rev_reg[22:20] == 3'h0 |=> settings.cap_halfamp == 8'h01;
  endproperty
  a_cap_half: assert property (p_cap_half) else $error("half ampere cap decode wrong");
  property p_quad_top;
    @(posedge aclk) disable iff (!aresetn)
      clk_en && rev_reg[26:23] == 4'hf |=> settings.quad_accel_centihz == 24'h0f_4240;
  endproperty
  a_quad_top: assert property (p_quad_top) else $error("quadratic top code wrong");

endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rdb_pkg::*;
  // ****************************************************************
  // Stimulus and observed signals.
  // ****************************************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic [9:0] s_axi_awaddr = 10'h000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [9:0] s_axi_araddr = 10'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  rdb_settings_t settings;
  logic [31:0] startup_config;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] word;
  logic [9:0] kp;
  localparam logic [31:0] LIN_TBL [16] = '{32'h1, 32'h5, 32'h64, 32'hfa, 32'h1f4, 32'h3e8,
    32'h9c4, 32'h1388, 32'h1d4c, 32'h2710, 32'h61a8, 32'hc350, 32'h124f8, 32'h186a0,
    32'h7a120, 32'hf4240};

  rdb_regs dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .settings(settings),
    .startup_config(startup_config));

  always #20 aclk = ~aclk;

  // ****************************************************************
  // Checking and closing.
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The whole run needs well under two thousand cycles.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end

  // ****************************************************************
  // Bus tasks.
  // ****************************************************************
  task automatic axi_write(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic reset_dut();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Settings lag the register by one cycle, so two edges pass before looking.
  task automatic chk_set(input logic [3:0] l, input logic [3:0] q, input logic [2:0] c,
                         input logic [9:0] p, input logic [9:0] k);
    repeat (2) @(posedge aclk);
    chk({8'h00, settings.lin_accel_centihz}, LIN_TBL[l]);
    chk({8'h00, settings.quad_accel_centihz}, (q == 4'h0) ? 32'h0 : LIN_TBL[q]);
    chk({24'h0, settings.cap_halfamp}, (c == 3'h0) ? 32'h1 : {28'h0, c, 1'b0});
    chk({22'h0, settings.kp_raw}, {22'h0, p});
    chk({22'h0, settings.ki_raw}, {22'h0, k});
  endtask

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    reset_dut();
    chk_set(4'h0, 4'h0, 3'h0, 10'h000, 10'h000);
    axi_read(RDB_ADDR_REV_BRAKE, 32'h0, RDB_RESP_OKAY);
    axi_read(RDB_ADDR_STARTUP1, 32'h0, RDB_RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      kp = {i[3:0], 6'h3f};
      word = {i[0], i[3:0], 4'hf - i[3:0], i[2:0], kp, 10'h3ff - kp};
      axi_write(RDB_ADDR_REV_BRAKE, word, 4'hf, RDB_RESP_OKAY);
      chk_set(i[3:0], 4'hf - i[3:0], i[2:0], kp, 10'h3ff - kp);
      axi_read(RDB_ADDR_REV_BRAKE, word, RDB_RESP_OKAY);
    end
    axi_write(RDB_ADDR_STARTUP1, 32'hffff_ffff, 4'hf, RDB_RESP_OKAY);
    axi_write(RDB_ADDR_STARTUP1, 32'h0, 4'h5, RDB_RESP_OKAY);
    axi_read(RDB_ADDR_STARTUP1, 32'hff00_ff00, RDB_RESP_OKAY);
    chk(startup_config, 32'hff00_ff00);
    // A write to an unmapped word must leave both registers alone.
    axi_write(10'h20c, 32'h1234_5678, 4'hf, RDB_RESP_SLVERR);
    axi_read(10'h20c, 32'h0, RDB_RESP_SLVERR);
    axi_read(RDB_ADDR_REV_BRAKE, word, RDB_RESP_OKAY);
    axi_read(RDB_ADDR_STARTUP1, 32'hff00_ff00, RDB_RESP_OKAY);
    clk_en <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({31'h0, s_axi_awready | s_axi_wready | s_axi_arready}, 32'h0);
    clk_en <= 1'b1;
    @(posedge aclk);
    reset_dut();
    chk_set(4'h0, 4'h0, 3'h0, 10'h000, 10'h000);
    chk(startup_config, 32'h0);
    axi_read(RDB_ADDR_REV_BRAKE, 32'h0, RDB_RESP_OKAY);
    end_sim();
  end
endmodule
`default_nettype wire
